// ### inc/alo_pkg.sv
package alo_pkg;
    // instruction word layout
    localparam int INSN_W = 10;
    localparam int NIB_W = 4;
    localparam logic [5:0] OPC_ADD_IMM_HI = 6'h06;  // upper six bits of add-immediate, low four hold n
    localparam logic [9:0] OPC_ADD_MEM = 10'h00A;
    localparam logic [9:0] OPC_ADD_MEM_CARRY = 10'h00B;
    localparam logic [9:0] OPC_AND_MEM = 10'h018;
    localparam int IMM_LSB = 0;
    localparam int IMM_MSB = 3;
    localparam int OPC_HI_LSB = 4;
    // reset values
    localparam logic [3:0] ACC_RST = 4'h0;
    localparam logic CARRY_RST = 1'h0;
    localparam logic SKIP_RST = 1'h0;
    localparam logic DONE_RST = 1'h0;

    // operation selected by the decoder
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_ADD_IMM = 3'b001,
        OP_ADD_MEM = 3'b010,
        OP_ADD_MEM_CARRY = 3'b011,
        OP_AND_MEM = 3'b100
    } alo_op_type;

    // one issued instruction with its memory operand
    typedef struct packed {
        logic valid;
        logic [9:0] word;
        logic [3:0] mem_nibble;
    } alo_issue_type;

    // architectural results after the instruction
    typedef struct packed {
        logic [3:0] acc;
        logic carry_flag;
        logic skip_next;
    } alo_state_type;
endpackage

// ### src/alo_exec.sv
// How it works
// - add-immediate adds low nibble n (0..15) to accumulator, one word, one cycle.
// - add-immediate without overflow skips next instruction; carry flag untouched.
// - add-immediate with overflow does not skip; accumulator keeps low four bits.
// - add-memory 00A adds addressed memory nibble to accumulator; carry flag unchanged.
// - add-memory-with-carry sums accumulator, memory, carry; carry-out loads carry flag.
// - AND 018 ands accumulator with addressed nibble; carry flag untouched; one cycle.
`timescale 1ns/1ns
module alo_exec
    import alo_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // issued instruction and memory nibble at the data pointer
    input wire alo_issue_type issue,
    // accumulator and carry flag, skip request for the sequencer
    output alo_state_type state,
    output logic done
);

    // decode of the instruction word
    function automatic alo_op_type decode(input logic [9:0] w);
        if (w[9:OPC_HI_LSB] == OPC_ADD_IMM_HI) begin
            decode = OP_ADD_IMM;
        end else if (w == OPC_ADD_MEM) begin
            decode = OP_ADD_MEM;
        end else if (w == OPC_ADD_MEM_CARRY) begin
            decode = OP_ADD_MEM_CARRY;
        end else if (w == OPC_AND_MEM) begin
            decode = OP_AND_MEM;
        end else begin
            decode = OP_NONE;
        end
    endfunction

    // datapath outline
    // one ripple adder serves all three additions, steered by the decoded op
    // the immediate and memory adds enter it with carry_in held low
    // the carry variant enters with the carry flag and loads its carry out
    // the AND path bypasses the adder and never touches the carry flag
    // an idle slot or an unknown word holds acc and carry and clears skip and done

    // full-adder sum bit, one per stage of the ripple chain
    function automatic logic fa_sum(input logic x, input logic y, input logic cin);
        fa_sum = x ^ y ^ cin;
    endfunction

    // full-adder carry bit, the majority of its three inputs
    function automatic logic fa_carry(input logic x, input logic y, input logic cin);
        fa_carry = (x & y) | (x & cin) | (y & cin);
    endfunction

    // operations whose accumulator result comes from the shared adder
    function automatic logic op_uses_adder(input alo_op_type o);
        case (o)
            OP_ADD_IMM: begin
                op_uses_adder = 1'h1;
            end
            OP_ADD_MEM: begin
                op_uses_adder = 1'h1;
            end
            OP_ADD_MEM_CARRY: begin
                op_uses_adder = 1'h1;
            end
            default: begin
                op_uses_adder = 1'h0;
            end
        endcase
    endfunction

    // operations that take their second operand from data memory
    function automatic logic op_reads_memory(input alo_op_type o);
        case (o)
            OP_ADD_MEM: begin
                op_reads_memory = 1'h1;
            end
            OP_ADD_MEM_CARRY: begin
                op_reads_memory = 1'h1;
            end
            OP_AND_MEM: begin
                op_reads_memory = 1'h1;
            end
            default: begin
                op_reads_memory = 1'h0;
            end
        endcase
    endfunction

    // the one operation that both reads and loads the carry flag
    function automatic logic op_uses_carry(input alo_op_type o);
        case (o)
            OP_ADD_MEM_CARRY: begin
                op_uses_carry = 1'h1;
            end
            default: begin
                op_uses_carry = 1'h0;
            end
        endcase
    endfunction

    // the one operation that may ask the sequencer to skip
    function automatic logic op_may_skip(input alo_op_type o);
        case (o)
            OP_ADD_IMM: begin
                op_may_skip = 1'h1;
            end
            default: begin
                op_may_skip = 1'h0;
            end
        endcase
    endfunction

    // the one operation that bypasses the adder
    function automatic logic op_is_and(input alo_op_type o);
        case (o)
            OP_AND_MEM: begin
                op_is_and = 1'h1;
            end
            default: begin
                op_is_and = 1'h0;
            end
        endcase
    endfunction

    // architectural registers and their next values
    logic [3:0] acc_q;
    logic [3:0] acc_d;
    logic carry_q;
    logic carry_d;
    logic skip_q;
    logic skip_d;
    logic done_q;
    logic done_d;

    // decoded operation and its steering strobes
    alo_op_type op;
    logic uses_adder;
    logic reads_memory;
    logic uses_carry;
    logic may_skip;
    logic is_and_mem;

    // shared adder operands, ripple chain and results
    logic [NIB_W-1:0] imm_n;
    logic [NIB_W-1:0] opnd_b;
    logic carry_in;
    wire [NIB_W:0] ripple;
    wire [NIB_W-1:0] sum_bits;
    wire [NIB_W-1:0] and_bits;
    logic carry_out;
    logic imm_ovf;

    // decode once per edge; an idle slot or an unknown word becomes OP_NONE
    assign op = issue.valid ? decode(issue.word) : OP_NONE;
    assign uses_adder = op_uses_adder(op);
    assign reads_memory = op_reads_memory(op);
    assign uses_carry = op_uses_carry(op);
    assign may_skip = op_may_skip(op);
    assign is_and_mem = op_is_and(op);

    // second operand: immediate field n, or the nibble at the data pointer
    assign imm_n = issue.word[IMM_MSB:IMM_LSB];
    assign opnd_b = reads_memory ? issue.mem_nibble : imm_n;

    // only the carry variant feeds the carry flag into bit 0
    assign carry_in = uses_carry ? carry_q : 1'h0;
    assign ripple[0] = carry_in;

    // four-stage ripple adder shared by all three additions
    // one chain in the datapath instead of three parallel adders
    for (genvar i = 0; i < NIB_W; i++) begin : g_add
        assign sum_bits[i] = fa_sum(acc_q[i], opnd_b[i], ripple[i]);
        assign ripple[i + 1] = fa_carry(acc_q[i], opnd_b[i], ripple[i]);
    end

    // bitwise AND with the addressed nibble, one gate per bit
    for (genvar j = 0; j < NIB_W; j++) begin : g_and
        assign and_bits[j] = acc_q[j] & issue.mem_nibble[j];
    end

    // carry out of bit 3; with carry_in low this is the immediate overflow
    assign carry_out = ripple[NIB_W];
    assign imm_ovf = carry_out;

    // accumulator: AND result, low four bits of the sum, or held
    assign acc_d = is_and_mem ? and_bits : (uses_adder ? sum_bits : acc_q);
    // carry flag: loaded by the carry variant only, every other word leaves it
    assign carry_d = uses_carry ? carry_out : carry_q;
    // skip request when the immediate add stayed inside four bits
    assign skip_d = may_skip & ~imm_ovf;
    // completion pulse for every recognised word
    assign done_d = (op != OP_NONE);

    // results land one edge after the word is taken
    // skip_next and done stand for that one cycle only,
    // so the sequencer must act on skip_next before the next edge

    // accumulator register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            acc_q <= ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    // carry flag register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            carry_q <= CARRY_RST;
        end else begin
            carry_q <= carry_d;
        end
    end

    // skip request register, a one-cycle pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            skip_q <= SKIP_RST;
        end else begin
            skip_q <= skip_d;
        end
    end

    // completion register, a one-cycle pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            done_q <= DONE_RST;
        end else begin
            done_q <= done_d;
        end
    end

    // outputs come straight from the registers
    assign state = '{acc: acc_q, carry_flag: carry_q, skip_next: skip_q};
    assign done = done_q;
endmodule

// ### sim/alo_exec_asserts.sv
`timescale 1ns/1ns
module alo_exec_chk
    import alo_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports of the block
    input wire alo_issue_type issue,
    input wire alo_state_type state,
    input wire logic done
);
    // decode of the issued word and expected sums
    wire im = issue.valid && issue.word[9:4] == OPC_ADD_IMM_HI;
    wire am = issue.valid && issue.word == OPC_ADD_MEM;
    wire ac = issue.valid && issue.word == OPC_ADD_MEM_CARRY;
    wire an = issue.valid && issue.word == OPC_AND_MEM;
    wire [3:0] a = state.acc;
    wire c = state.carry_flag;
    wire [4:0] si = a + issue.word[3:0];
    wire [4:0] sc = a + issue.mem_nibble + c;
    wire ov = si[4];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_imm_sum: assert property (im |=> a == $past(si[3:0]) && $stable(c)) else $error("imm sum");
    a_imm_skip: assert property (im && !ov |=> state.skip_next && done) else $error("imm skip");
    a_imm_noskip: assert property (im && ov |=> !state.skip_next && done) else $error("imm noskip");
    a_mem_sum: assert property (am |=> a == $past(a + issue.mem_nibble) && $stable(c)) else $error("mem");
    a_carry_sum: assert property (ac |=> {c, a} == $past(sc) && done) else $error("carry sum");
    a_and_mem: assert property (an |=> a == $past(a & issue.mem_nibble) && $stable(c)) else $error("and");
    a_ovf_bit: assert property (im |=> state.skip_next == !$past(ov)) else $error("overflow");
    a_mem_done: assert property ((am || an) |=> done && !state.skip_next) else $error("mem done");
    a_idle_hold: assert property (!(im || am || ac || an) |=> $stable(a) && $stable(c) && !done && !state.skip_next)
        else $error("idle hold");
endmodule
bind alo_exec alo_exec_chk i_chk(.sys_clk(sys_clk), .rst(rst), .done(done), .issue(issue), .state(state));

// ### sim/alo_exec_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module alo_exec_tb_top import alo_pkg::*; ;
    logic sys_clk = 1'h0, rst = 1'h1, done;
    alo_issue_type issue = '0;
    alo_state_type state;
    int miscompares = 0, checked = 0;
    alo_exec i_alo_exec(.sys_clk(sys_clk), .rst(rst), .issue(issue), .state(state), .done(done));
    // 100 ns clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // issue one word, judge acc, carry, skip and done one edge later
    task iss(input logic [9:0] w, input logic [3:0] m, a, input logic c, s);
        @(negedge sys_clk) issue <= '{1'b1, w, m};
        @(negedge sys_clk) issue.valid <= 1'h0;
        `CHK("state", {a, c, s, w != 10'h3FF}, {state, done})
    endtask
    task t_imm;
        iss(10'h065, 4'hF, 4'h5, 1'h0, 1'h1);
        iss(10'h06F, 4'h0, 4'h4, 1'h0, 1'h0);
        $display("t_imm end");
    endtask
    task t_mem;
        iss(10'h00A, 4'hE, 4'h2, 1'h0, 1'h0);
        iss(10'h00B, 4'hF, 4'h1, 1'h1, 1'h0);
        iss(10'h018, 4'h7, 4'h1, 1'h1, 1'h0);
        iss(10'h00A, 4'h9, 4'hA, 1'h1, 1'h0);
        iss(10'h063, 4'h0, 4'hD, 1'h1, 1'h1);
        iss(10'h00B, 4'h2, 4'h0, 1'h1, 1'h0);
        iss(10'h3FF, 4'h5, 4'h0, 1'h1, 1'h0);
        $display("t_mem end");
    endtask
    // reset in mid-run clears acc and carry, then the block works again
    task t_rst;
        iss(10'h067, 4'h0, 4'h7, 1'h1, 1'h1);
        @(negedge sys_clk) rst = 1'h1;
        @(negedge sys_clk);
        `CHK("reset", 7'h00, {state, done})
        rst = 1'h0;
        iss(10'h00B, 4'hF, 4'hF, 1'h0, 1'h0);
        $display("t_rst end");
    endtask
    task print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reset until the third falling edge (three rising edges), then the scenarios
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'h0;
        t_imm();
        t_mem();
        t_rst();
        print_verdict();
    end
endmodule
